/* rtl/serial_io_pkg.sv */
// constants, field positions and state encodings of the serial i/o unit
package serial_io_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_DATA    = 6'h18;
  localparam logic [5:0] IDX_STATUS  = 6'h19;
  localparam logic [5:0] IDX_CONTROL = 6'h1a;
  localparam logic [5:0] IDX_FRAME   = 6'h1b;
  localparam logic [5:0] IDX_RATE    = 6'h1c;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CT_CSS  = 0;
  localparam int CT_SCS  = 1;
  localparam int CT_SERIAL_READY_OUT = 2;
  localparam int CT_TIC  = 3;
  localparam int CT_TE   = 4;
  localparam int CT_RE   = 5;
  localparam int CT_MODE = 6;
  localparam int CT_EN   = 7;

  // ----------------------------------------------------------------
  // frame format register fields
  // ----------------------------------------------------------------
  localparam int FM_CHAR = 0;
  localparam int FM_PARITY_ENABLE_BIT = 1;
  localparam int FM_ODD  = 2;
  localparam int FM_STOP = 3;
  localparam int FM_OD   = 4;

  // ----------------------------------------------------------------
  // reset values, fill bits and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [4:0] FRAME_RST   = 5'h00;
  localparam logic [7:0] RATE_RST    = 8'h00;
  localparam logic [2:0] FRAME_FILL  = 3'h7;
  localparam logic [3:0] OS_LAST     = 4'hf;
  localparam logic [3:0] OS_MID      = 4'h7;
  localparam logic [2:0] BITS8_LAST  = 3'h7;
  localparam logic [2:0] BITS7_LAST  = 3'h6;
  localparam logic [1:0] PRE_LAST    = 2'h3;
  localparam int         RATE_W      = 8;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } rx_state_t;

endpackage

/* rtl/rate_if.sv */
// interface between the unit and its baud rate generator
`timescale 1ns/10ps
interface rate_if #(parameter int WIDTH = 8);
  logic             src_div4;
  logic [WIDTH-1:0] reload;
  logic             tick;
  modport gen  (input src_div4, input reload, output tick);
  modport user (output src_div4, output reload, input tick);
endinterface

/* rtl/baud_rate_generator.sv */
// reloading down counter that makes the baud rate tick
`timescale 1ns/10ps
module baud_rate_generator
  import serial_io_pkg::*;
#(
  parameter int WIDTH = RATE_W
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  rate_if.gen       rate
);

  typedef struct packed {
    logic [1:0]       pre;
    logic [WIDTH-1:0] cnt;
    logic             tick;
  } gen_state_t;

  gen_state_t s;
  gen_state_t next_s;

  // prescale by four when selected, then count reload+1 source clocks
  always_comb begin
    logic src;
    src = 1'b0;
    next_s = s;
    next_s.tick = 1'b0;
    next_s.pre = 2'(s.pre + 2'h1);
    src = rate.src_div4 ? (s.pre == PRE_LAST) : 1'b1;
    if (src) begin
      if (s.cnt == '0) begin
        next_s.cnt = rate.reload;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = WIDTH'(s.cnt - 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rate.tick = s.tick;

endmodule

/* rtl/serial_io_unit.sv */
// serial i/o unit: uart or clock synchronous port behind a wishbone slave
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
// Behaviour
// - status bit 0: transmit buffer empty
// - status bit 1: received character waiting
// - status bit 2: transmit shift finished
// - status bit 3: receive overrun seen
// - status bit 4: parity check failed
// - status bit 5: bad stop bit seen
// - status bit 6: or of three errors
// - status bit 7 reads one; writes ignored
// - control bit 0: generator source divide four
// - control bit 1: internal or external shift clock
// - control bit 2: drive serial ready pin
// - control bit 3: transmit interrupt source
// - control bit 4: transmit enable, reset clear
// - control bit 5: receive enable, reset clear
// - control bit 6: uart or synchronous mode
// - control bit 7: unit enable owns pins
// - format bit 0: seven or eight bits in uart mode; synchronous mode always eight
// - format bits 1,2: parity on, odd
// - format bit 3: one or two stops
// - format bit 4: open drain transmit pin
// - format bits 5-7 read one, unwritable
module serial_io_unit
  import serial_io_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxd_i,
  input  wire logic        sclk_i,
  output logic             txd_o,
  output logic             txd_oe_n_o,
  output logic             sclk_o,
  output logic             sclk_oe_n_o,
  output logic             serial_ready_o,
  output logic             serial_ready_oe_n_o,
  output logic             tx_irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ack;
    logic [7:0]  rdat;
    logic [7:0]  ctrl;
    logic [4:0]  fmt;
    logic [7:0]  rate;
    logic [7:0]  tbuf;
    logic        tpend;
    logic        tx_buffer_empty_flag;
    logic        tx_shift_done_flag;
    tx_state_t   tst;
    logic [7:0]  tsh;
    logic [3:0]  tos;
    logic [2:0]  tbit;
    logic        tpar;
    logic        tstop;
    logic        txd;
    rx_state_t   rst_s;
    logic [7:0]  rsh;
    logic [3:0]  ros;
    logic [2:0]  rbit;
    logic        rpar;
    logic        ppend;
    logic [7:0]  rbuf;
    logic        rx_buffer_full_flag;
    logic        ovr;
    logic        perr;
    logic        ferr;
    logic [1:0]  rx_sync;
    logic [1:0]  ck_sync;
    logic        ck_prev;
    logic        sph;
    logic        sclk;
    logic        txo;
    logic        txd_oe_n;
    logic        sclk_oe_n;
    logic        serial_ready_out;
    logic        serial_ready_out_oe_n;
    logic        irq;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;

  rate_if #(.WIDTH(RATE_W)) rate ();

  baud_rate_generator #(.WIDTH(RATE_W)) u_gen (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .rate  (rate)
  );

  assign rate.src_div4 = s.ctrl[CT_CSS];
  assign rate.reload   = s.rate;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0] idx;
    logic       req;
    logic       wr;
    logic       rd;
    logic       en;
    logic       mode;
    logic       odd;
    logic       ck_rise;
    logic       ck_fall;
    logic       os_tick;
    logic       s_rise;
    logic       s_fall;
    logic       tx_evt;
    logic       rx_evt;
    logic       rxbit;
    logic [2:0] last;
    logic       done;
    logic       fe_now;
    logic [7:0] word;
    logic [7:0] status;
    idx = wb_adr_i[7:2];
    req = wb_cyc_i & wb_stb_i;
    wr = req & wb_we_i & s.ack & wb_sel_i[0];
    rd = req & ~wb_we_i & s.ack;
    en = s.ctrl[CT_EN];
    mode = s.ctrl[CT_MODE];
    odd = s.fmt[FM_ODD];
    ck_rise = s.ck_sync[1] & ~s.ck_prev;
    ck_fall = ~s.ck_sync[1] & s.ck_prev;
    rxbit = s.rx_sync[1];
    done = 1'b0;
    fe_now = 1'b0;
    word = s.rsh;
    status = {1'b1, s.ovr | s.perr | s.ferr, s.ferr, s.perr, s.ovr, s.tx_shift_done_flag, s.rx_buffer_full_flag, s.tx_buffer_empty_flag};
    next_s = s;

    // pin synchronisers: first stage only feeds the second
    next_s.rx_sync = {s.rx_sync[0], rxd_i};
    next_s.ck_sync = {s.ck_sync[0], sclk_i};
    next_s.ck_prev = s.ck_sync[1];

    // uart oversample tick: generator or external clock, sixteen per bit
    os_tick = s.ctrl[CT_SCS] ? ck_rise : rate.tick;

    // synchronous clock: generator/4 driven out while sending, or external
    s_rise = 1'b0;
    s_fall = 1'b0;
    if (s.ctrl[CT_SCS]) begin
      s_rise = ck_rise;
      s_fall = ck_fall;
    end else if (mode && s.tst != TX_IDLE && rate.tick) begin
      next_s.sph = ~s.sph;
      if (s.sph) begin
        next_s.sclk = ~s.sclk;
        s_rise = ~s.sclk;
        s_fall = s.sclk;
      end
    end
    if (!mode || s.tst == TX_IDLE) begin
      next_s.sclk = 1'b1; // clock idles high between characters
    end

    last = (!mode && s.fmt[FM_CHAR]) ? BITS7_LAST : BITS8_LAST;
    tx_evt = mode ? s_fall : (os_tick && s.tos == OS_LAST);
    rx_evt = mode ? s_rise : (os_tick && s.ros == OS_LAST);

    // bus answer: ack one cycle after the request, data with it
    next_s.ack = req & ~s.ack;
    next_s.rdat = 8'h00;
    if (req && !s.ack) begin
      case (idx)
        IDX_DATA:    next_s.rdat = s.rbuf;
        IDX_STATUS:  next_s.rdat = status;
        IDX_CONTROL: next_s.rdat = s.ctrl;
        IDX_FRAME:   next_s.rdat = {FRAME_FILL, s.fmt};
        IDX_RATE:    next_s.rdat = s.rate;
        default:     next_s.rdat = 8'h00;
      endcase
    end

    // reading the character empties the buffer and clears the errors
    if (rd && idx == IDX_DATA) begin
      next_s.rx_buffer_full_flag = 1'b0;
      next_s.ovr = 1'b0;
      next_s.perr = 1'b0;
      next_s.ferr = 1'b0;
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    if (s.tst != TX_IDLE && os_tick) begin
      next_s.tos = 4'(s.tos + 4'h1);
    end
    case (s.tst)
      TX_IDLE: begin
        if (en && s.ctrl[CT_TE] && s.tpend) begin
          next_s.tsh = s.tbuf;
          next_s.tpend = 1'b0;
          next_s.tx_buffer_empty_flag = 1'b1;
          next_s.tx_shift_done_flag = 1'b0;
          next_s.tbit = 3'h0;
          next_s.tos = 4'h0;
          next_s.tpar = 1'b0;
          next_s.tstop = 1'b0;
          // sync mode idles high in start until the first falling clock edge
          next_s.tst = TX_START;
          next_s.txd = mode;
        end
      end
      TX_START: begin
        if (tx_evt) begin
          next_s.tst = TX_DATA;
          next_s.txd = s.tsh[0];
        end
      end
      TX_DATA: begin
        // sync mode ends on the last rising edge, so no extra clock follows
        if (mode && s_rise && s.tbit == last) begin
          next_s.tst = TX_IDLE;
          next_s.tx_shift_done_flag = 1'b1;
          next_s.txd = 1'b1;
        end else if (tx_evt) begin
          next_s.tpar = s.tpar ^ s.tsh[0];
          next_s.tsh = {1'b0, s.tsh[7:1]};
          next_s.tbit = 3'(s.tbit + 3'h1);
          next_s.txd = s.tsh[1];
          if (s.tbit == last) begin
            if (s.fmt[FM_PARITY_ENABLE_BIT]) begin
              next_s.tst = TX_PAR;
              next_s.txd = s.tpar ^ s.tsh[0] ^ odd;
            end else begin
              next_s.tst = TX_STOP;
              next_s.txd = 1'b1;
            end
          end
        end
      end
      TX_PAR: begin
        if (tx_evt) begin
          next_s.tst = TX_STOP;
          next_s.txd = 1'b1;
        end
      end
      TX_STOP: begin
        if (tx_evt) begin
          if (s.fmt[FM_STOP] && !s.tstop) begin
            next_s.tstop = 1'b1;
          end else begin
            next_s.tst = TX_IDLE;
            next_s.tx_shift_done_flag = 1'b1;
          end
        end
      end
      default: next_s.tst = TX_IDLE;
    endcase
    // disabling abandons the character in the shifter
    if (!en || !s.ctrl[CT_TE]) begin
      next_s.tst = TX_IDLE;
      next_s.txd = 1'b1;
    end

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    if (s.rst_s != RX_IDLE && os_tick) begin
      next_s.ros = 4'(s.ros + 4'h1);
    end
    case (s.rst_s)
      RX_IDLE: begin
        next_s.rbit = 3'h0;
        next_s.rpar = 1'b0;
        next_s.ppend = 1'b0;
        next_s.ros = 4'h0;
        if (en && s.ctrl[CT_RE]) begin
          if (mode) begin
            next_s.rst_s = RX_DATA;
          end else if (os_tick && !rxbit) begin
            next_s.rst_s = RX_START;
          end
        end
      end
      RX_START: begin
        // recheck the start bit at its middle to reject glitches
        if (os_tick && s.ros == OS_MID) begin
          next_s.ros = 4'h0;
          next_s.rst_s = rxbit ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_evt) begin
          next_s.rsh = {rxbit, s.rsh[7:1]};
          next_s.rpar = s.rpar ^ rxbit;
          next_s.rbit = 3'(s.rbit + 3'h1);
          if (s.rbit == last) begin
            if (mode) begin
              done = 1'b1;
              word = {rxbit, s.rsh[7:1]};
              next_s.rst_s = RX_IDLE;
            end else begin
              next_s.rst_s = s.fmt[FM_PARITY_ENABLE_BIT] ? RX_PAR : RX_STOP;
            end
          end
        end
      end
      RX_PAR: begin
        if (rx_evt) begin
          next_s.ppend = rxbit ^ s.rpar ^ odd;
          next_s.rst_s = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_evt) begin
          done = 1'b1;
          fe_now = ~rxbit;
          word = s.fmt[FM_CHAR] ? {1'b0, s.rsh[7:1]} : s.rsh;
          next_s.rst_s = RX_IDLE;
        end
      end
      default: next_s.rst_s = RX_IDLE;
    endcase
    if (!en || !s.ctrl[CT_RE]) begin
      next_s.rst_s = RX_IDLE;
    end
    // completion beats a same-cycle read, which frees the buffer for it
    if (done) begin
      if (s.rx_buffer_full_flag && !(rd && idx == IDX_DATA)) begin
        next_s.ovr = 1'b1;
      end else begin
        next_s.rbuf = word;
        next_s.rx_buffer_full_flag = 1'b1;
      end
      next_s.perr = next_s.perr | s.ppend;
      next_s.ferr = next_s.ferr | fe_now;
    end

    // register writes; status has no write path at all
    if (wr) begin
      case (idx)
        IDX_DATA: begin
          next_s.tbuf = wb_dat_i[7:0];
          next_s.tpend = 1'b1;
          next_s.tx_buffer_empty_flag = 1'b0;
        end
        IDX_CONTROL: next_s.ctrl = wb_dat_i[7:0];
        IDX_FRAME:   next_s.fmt = wb_dat_i[4:0];
        IDX_RATE:    next_s.rate = wb_dat_i[7:0];
        default:     next_s.rate = s.rate;
      endcase
    end

    // ----------------------------------------------------------------
    // pins: released whenever the unit is disabled
    // ----------------------------------------------------------------
    next_s.txo = s.fmt[FM_OD] ? 1'b0 : next_s.txd;
    next_s.txd_oe_n = ~en | (s.fmt[FM_OD] & next_s.txd);
    next_s.sclk_oe_n = ~(en & mode & ~s.ctrl[CT_SCS]);
    next_s.serial_ready_out = s.ctrl[CT_RE] & ~s.rx_buffer_full_flag;
    next_s.serial_ready_out_oe_n = ~(en & s.ctrl[CT_SERIAL_READY_OUT]);
    next_s.irq = en & s.ctrl[CT_TE] & (s.ctrl[CT_TIC] ? s.tx_shift_done_flag : s.tx_buffer_empty_flag);
  end

  // single register stage for the whole unit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.ctrl <= CONTROL_RST;
      s.fmt <= FRAME_RST;
      s.rate <= RATE_RST;
      s.tst <= TX_IDLE;
      s.rst_s <= RX_IDLE;
      s.txd <= 1'b1;
      s.txo <= 1'b1;
      s.sclk <= 1'b1;
      s.rx_sync <= 2'h3;
      s.ck_sync <= 2'h3;
      s.ck_prev <= 1'b1;
      s.txd_oe_n <= 1'b1;
      s.sclk_oe_n <= 1'b1;
      s.serial_ready_out_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = {24'h000000, s.rdat};
  assign wb_ack_o = s.ack;
  assign txd_o = s.txo;
  assign txd_oe_n_o = s.txd_oe_n;
  assign sclk_o = s.sclk;
  assign sclk_oe_n_o = s.sclk_oe_n;
  assign serial_ready_o = s.serial_ready_out;
  assign serial_ready_oe_n_o = s.serial_ready_out_oe_n;
  assign tx_irq_o = s.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  summary_bit_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && wb_adr_i[7:2] == IDX_STATUS && !wb_we_i)
      |-> wb_dat_o[6] == (wb_dat_o[3] | wb_dat_o[4] | wb_dat_o[5]))
    else $error("summary error bit disagrees with error flags");

  status_top_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && wb_adr_i[7:2] == IDX_STATUS && !wb_we_i) |-> wb_dat_o[7:0] >= 8'h80)
    else $error("status bit 7 not read as one");

  frame_fill_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && wb_adr_i[7:2] == IDX_FRAME && !wb_we_i) |-> wb_dat_o[7:5] == 3'h7)
    else $error("format bits 5-7 not read as one");

  tx_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
      && wb_adr_i[7:2] == IDX_DATA) |=> !s.tx_buffer_empty_flag ##1 (s.tx_buffer_empty_flag || s.tpend))
    else $error("empty flag not cleared by a character write");

  tx_load_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s.tst == TX_IDLE && $past(s.tst) == TX_IDLE && s.tpend
      && s.ctrl[CT_EN] && s.ctrl[CT_TE]) |=> s.tx_buffer_empty_flag && !s.tx_shift_done_flag && s.tst != TX_IDLE)
    else $error("load did not set empty and clear completion");

  tx_off_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !s.ctrl[CT_TE] |=> s.tst == TX_IDLE && (txd_o || txd_oe_n_o))
    else $error("transmitter active while disabled");

  rx_off_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!s.ctrl[CT_RE] && s.rst_s == RX_IDLE) |=> $stable(s.rx_buffer_full_flag) || !s.rx_buffer_full_flag)
    else $error("receive buffer filled while receive disabled");

  overrun_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s.rst_s == RX_STOP && $past(s.rx_buffer_full_flag) && s.rx_buffer_full_flag && s.ctrl[CT_RE] && s.ctrl[CT_EN]
      && !s.ctrl[CT_MODE] && s.ros == OS_LAST && rate.tick && !s.ctrl[CT_SCS])
      |=> s.ovr)
    else $error("overrun not flagged on full buffer");

  open_drain_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($past(s.fmt[FM_OD]) && !txd_oe_n_o) |-> !txd_o)
    else $error("open drain pin driven high");

  unit_off_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !s.ctrl[CT_EN] ##1 !s.ctrl[CT_EN] |-> txd_oe_n_o && sclk_oe_n_o && serial_ready_oe_n_o)
    else $error("pins driven while unit disabled");

endmodule

/* test/uart_peer.sv */
// far side model: remote uart transmitter and receiver
`timescale 1ns/10ps
module uart_peer (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      rxd_o
);
  // line rests at mark between frames
  initial rxd_o = 1'b1;

  // ----------------------------------------------------------------
  // send one frame: bad[0] flips parity, bad[1] pulls the stop bit low
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic [7:0] fmt,
                      input logic [1:0] bad, input int bc);
    logic [12:0] f;
    int          n;
    f = '1;
    f[0] = 1'b0;
    n = 1;
    for (int i = 0; i < (fmt[0] ? 7 : 8); i++) begin
      f[n] = d[i];
      n++;
    end
    if (fmt[1]) begin
      f[n] = ^(d & (fmt[0] ? 8'h7f : 8'hff)) ^ fmt[2] ^ bad[0];
      n++;
    end
    f[n] = ~bad[1];
    n = n + 2 + int'(fmt[3]);
    // whole frame plus one idle bit, so the stop sample settles
    for (int i = 0; i < n; i++) begin
      rxd_o <= f[i];
      repeat (bc) @(posedge clk_i);
    end
  endtask

  // ----------------------------------------------------------------
  // capture eight data bits, sampled in the middle of each bit
  // ----------------------------------------------------------------
  task automatic recv(output logic [7:0] d, input int bc);
    while (line_i) @(posedge clk_i);
    repeat (bc / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bc) @(posedge clk_i);
      d[i] = line_i;
    end
  endtask
endmodule

/* test/tb_top.sv */
// self-checking bench of the serial i/o unit: registers and uart traffic
`timescale 1ns/10ps
module tb_top;
  import serial_io_pkg::*;

  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_we   = 1'b0;
  logic [7:0]  wb_adr  = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        rxd;
  logic        txd;
  logic        txd_oe_n;
  logic        serial_ready_out;
  logic        serial_ready_out_oe_n;
  logic        tx_irq;
  logic        sclk;
  logic [31:0] rdat;
  logic [7:0]  got;
  logic [47:0] r;
  logic [47:0] rx_rows [7];
  logic [23:0] reg_rows [6];
  int          num_errors = 0;
  int          compares   = 0;
  int          cycles     = 0;
  // open drain line is pulled up whenever the pin is released
  wire         txd_line   = txd_oe_n ? 1'b1 : txd;

  always #5 clk_i = ~clk_i;

  serial_io_unit dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rxd_i(rxd), .sclk_i(1'b1),
    .txd_o(txd), .txd_oe_n_o(txd_oe_n), .sclk_o(sclk), .sclk_oe_n_o(),
    .serial_ready_o(serial_ready_out), .serial_ready_oe_n_o(serial_ready_out_oe_n), .tx_irq_o(tx_irq));

  uart_peer peer_u (.clk_i(clk_i), .line_i(txd_line), .rxd_o(rxd));

  // ----------------------------------------------------------------
  // checking, bus access and closing
  // ----------------------------------------------------------------
  task end_sim;
    $display("errors %0d, compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; request held until ack is sampled at an edge
  task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] wd);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= {idx, 2'b00};
    wb_wdat <= {24'h0, wd};
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rd(input logic [5:0] idx);
    xfer(1'b0, idx, 8'h00);
  endtask

  // let registered pin outputs land, then sample between edges
  task automatic gap;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    // index, write value, value read back
    reg_rows = '{24'h1b_ff_ff, 24'h1b_00_e0, 24'h19_ff_80, 24'h1a_5a_5a,
                 24'h1a_a5_a5, 24'h3f_ff_00};
    // control, format, data, faults, data read, status bits 6..1
    rx_rows = '{48'ha0_00_5a_00_5a_02, 48'ha0_01_d5_00_55_02, 48'ha0_02_37_00_37_02,
                48'ha0_06_38_00_38_02, 48'ha0_06_37_01_37_52, 48'ha0_00_a1_02_a1_62,
                48'ha1_08_3c_00_3c_02};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (reg_rows[k]) begin
      wr(reg_rows[k][21:16], reg_rows[k][15:8]);
      rd(reg_rows[k][21:16]);
      chk("reg", rdat, {24'h0, reg_rows[k][7:0]});
    end
    // ready pin handed over only with unit enable and its own bit
    wr(IDX_CONTROL, 8'ha4);
    gap();
    chk("ready oe", 32'(serial_ready_out_oe_n), 32'h0);
    chk("ready", 32'(serial_ready_out), 32'h1);
    @(posedge clk_i);
    wr(IDX_CONTROL, 8'h24);
    gap();
    chk("ready oe off", 32'(serial_ready_out_oe_n), 32'h1);
    @(posedge clk_i);
    // received frames of each format and fault; the last runs at divide four
    foreach (rx_rows[k]) begin
      r = rx_rows[k];
      wr(IDX_CONTROL, r[47:40]);
      wr(IDX_FRAME, r[39:32]);
      peer_u.send(r[31:24], r[39:32], r[17:16], r[40] ? 64 : 16);
      rd(IDX_STATUS);
      chk("status", rdat & 32'h7e, {24'h0, r[7:0]});
      rd(IDX_DATA);
      chk("rx data", rdat, {24'h0, r[15:8]});
      rd(IDX_STATUS);
      chk("status clr", rdat & 32'h7e, 32'h0);
    end
    // second character arrives before the first is read
    peer_u.send(8'h11, 8'h08, 2'b00, 64);
    peer_u.send(8'h22, 8'h08, 2'b00, 64);
    rd(IDX_STATUS);
    chk("overrun", rdat & 32'h7e, 32'h4a);
    rd(IDX_DATA);
    chk("kept char", rdat, 32'h11);
    // transmit, first with the transmitter held off
    wr(IDX_FRAME, 8'h00);
    wr(IDX_CONTROL, 8'h80);
    wr(IDX_DATA, 8'h96);
    rd(IDX_STATUS);
    chk("tbe write", rdat & 32'h1, 32'h0);
    chk("irq off", 32'(tx_irq), 32'h0);
    wr(IDX_CONTROL, 8'h90);
    peer_u.recv(got, 16);
    chk("tx data", 32'(got), 32'h96);
    repeat (32) @(posedge clk_i);
    rd(IDX_STATUS);
    chk("tx done", rdat & 32'h5, 32'h5);
    chk("irq empty", 32'(tx_irq), 32'h1);
    chk("pp oe", 32'(txd_oe_n), 32'h0);
    // open drain line, interrupt on shift completion
    wr(IDX_FRAME, 8'h10);
    gap();
    chk("od oe", 32'(txd_oe_n), 32'h1);
    @(posedge clk_i);
    wr(IDX_CONTROL, 8'h98);
    wr(IDX_DATA, 8'h3c);
    peer_u.recv(got, 16);
    chk("od data", 32'(got), 32'h3c);
    chk("irq shifting", 32'(tx_irq), 32'h0);
    repeat (32) @(posedge clk_i);
    chk("irq shifted", 32'(tx_irq), 32'h1);
    // synchronous transmit: data changes on the fall, is taken after each rise
    wr(IDX_CONTROL, 8'hd0);
    wr(IDX_DATA, 8'ha5);
    for (int i = 0; i < 8; i++) begin
      @(posedge sclk);
      @(negedge clk_i);
      got[i] = txd_line;
    end
    chk("sync data", 32'(got), 32'ha5);
    repeat (8) @(posedge clk_i);
    rd(IDX_STATUS);
    chk("sync done", rdat & 32'h5, 32'h5);
    // reset in mid-run returns registers and pins to rest
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("rst irq", 32'(tx_irq), 32'h0);
    chk("rst oe", 32'(txd_oe_n), 32'h1);
    @(posedge clk_i);
    rd(IDX_CONTROL);
    chk("rst ctl", rdat, 32'h0);
    rd(IDX_STATUS);
    chk("rst sts", rdat, 32'h80);
    rd(IDX_FRAME);
    chk("rst fmt", rdat, 32'he0);
    end_sim();
  end
endmodule
